// file: rtl/acml_pkg.sv
// Constants for the converter control and mode logic.
// Assumes a classic Wishbone slave port with 32-bit words, one register per word.
package acml_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] CTRL0_IDX = 8'h97;
  localparam logic [7:0] MODEB_IDX = 8'hA1;
  localparam logic [7:0] MODEA_IDX = 8'hC0;
  localparam logic [7:0] AINS_IDX = 8'hA3;
  localparam int ADR_W = 12;
  localparam logic [ADR_W-1:0] CTRL0_ADR = {2'h0, CTRL0_IDX, 2'h0};
  localparam logic [ADR_W-1:0] MODEB_ADR = {2'h0, MODEB_IDX, 2'h0};
  localparam logic [ADR_W-1:0] MODEA_ADR = {2'h0, MODEA_IDX, 2'h0};
  localparam logic [ADR_W-1:0] AINS_ADR = {2'h0, AINS_IDX, 2'h0};
  localparam logic [7:0] REG_RESET = 8'h00;
  // Control register zero fields.
  localparam int C0_START_LO = 0;
  localparam int C0_START_HI = 1;
  localparam int C0_ENABLE = 2;
  localparam int C0_DONE = 3;
  localparam int C0_EDGE = 4;
  localparam int C0_TIMER = 5;
  localparam int C0_DONE_IE = 6;
  localparam int C0_BOUND_IE = 7;
  // Mode register A fields.
  localparam int MA_SINGLE = 4;
  localparam int MA_CHAN_CONT = 5;
  localparam int MA_SCAN_CONT = 6;
  localparam int MA_BOUND = 7;
  localparam logic [7:0] MA_WMASK = 8'hF0;
  // Mode register B fields.
  localparam int MB_FOUR = 0;
  localparam int MB_ALL = 1;
  localparam int MB_INSIDE = 4;
  localparam int MB_DIV_LO = 5;
  localparam int MB_DIV_HI = 7;
  localparam logic [7:0] MB_WMASK = 8'hF3;
  // Start mode codes.
  localparam logic [1:0] START_TIMER = 2'h0;
  localparam logic [1:0] START_NOW = 2'h1;
  localparam logic [1:0] START_EDGE = 2'h2;
  // Conversion mode codes {scan continuous, channel continuous, single}.
  localparam logic [2:0] MODE_STEP = 3'h0;
  localparam logic [2:0] MODE_SINGLE = 3'h1;
  localparam logic [2:0] MODE_CHAN = 3'h2;
  localparam logic [2:0] MODE_SCAN = 3'h4;
  localparam logic [2:0] FOUR_CONV = 3'h4;
  localparam logic [3:0] MANY_CHANS = 4'h4;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_BUSY = 1'b1} acml_state_t;
endpackage : acml_pkg

// file: rtl/acml_top.sv
// Control and mode logic of an eight-input successive-approximation converter.
// Assumes an analog core that reports each finished conversion and each finished set,
// and a system interrupt controller that supplies the A/D interrupt enable.
`timescale 1ns/1ns
`default_nettype none
module acml_top
  import acml_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [acml_pkg::ADR_W-1:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic TIMER0_OVF_I,
  input wire logic EDGE_TRIGGER_PIN_I,
  input wire logic IDLE_I,
  input wire logic POWER_DOWN_I,
  input wire logic AD_IRQ_ENABLE_I,
  input wire logic CONV_DONE_I,
  input wire logic SET_DONE_I,
  input wire logic [2:0] CONV_CHANNEL_I,
  input wire logic RESULT_INSIDE_I,
  output logic CONV_START_O,
  output logic CONV_POWER_O,
  output logic CONV_CLK_EN_O,
  output logic [2:0] CONV_MODE_O,
  output logic [7:0] INPUT_ENABLE_O,
  output logic IRQ_O,
  output logic WAKE_O
);
  import acml_pkg::*;

  logic [7:0] ctrl_q;
  logic [7:0] mode_a_q;
  logic [7:0] mode_b_q;
  logic [7:0] ains_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  logic pin_lvl_q;
  logic pin_seen_q;
  logic [2:0] div_cnt_q;
  logic clk_en_q;
  logic start_q;
  logic power_q;
  logic [2:0] mode_q;
  logic [7:0] ain_out_q;
  logic irq_q;
  logic wake_q;
  logic [2:0] conv_cnt_q;
  acml_state_t state_q;

  logic req;
  logic wr_en;
  logic wr_ctrl;
  logic wr_mode_a;
  logic wr_mode_b;
  logic wr_ains;
  logic running;
  logic [1:0] start_mode;
  logic [2:0] conv_mode;
  logic [2:0] div_code;
  logic pin_rise;
  logic pin_fall;
  logic timer_go;
  logic edge_go;
  logic now_go;
  logic start_go;
  logic step_end;
  logic four_hit;
  logic bound_set;
  logic done_set;
  logic [3:0] chan_count;
  logic [31:0] rd_data;

  // Wishbone decode.
  assign req = CYC_I & STB_I & ~ack_q;
  assign wr_en = req & WE_I & SEL_I[0];
  assign wr_ctrl = wr_en & (ADR_I == CTRL0_ADR);
  assign wr_mode_a = wr_en & (ADR_I == MODEA_ADR);
  assign wr_mode_b = wr_en & (ADR_I == MODEB_ADR);
  assign wr_ains = wr_en & (ADR_I == AINS_ADR);

  assign running = ctrl_q[C0_ENABLE] & ~POWER_DOWN_I;
  assign start_mode = ctrl_q[C0_START_HI:C0_START_LO];
  assign conv_mode = mode_a_q[MA_SCAN_CONT:MA_SINGLE];
  assign div_code = mode_b_q[MB_DIV_HI:MB_DIV_LO];

  // Number of selected inputs.
  always_comb begin
    chan_count = 4'h0;
    for (int i = 0; i < 8; i++) begin
      chan_count = chan_count + {3'h0, ains_q[i]};
    end
  end

  // Edges of the filtered pin level.
  assign pin_rise = (pin_s2_q == pin_s3_q) & pin_s3_q & ~pin_lvl_q & pin_seen_q;
  assign pin_fall = (pin_s2_q == pin_s3_q) & ~pin_s3_q & pin_lvl_q & pin_seen_q;

  // Start sources; triggers are ignored while a conversion runs.
  assign timer_go = (start_mode == START_TIMER) & ctrl_q[C0_TIMER] & TIMER0_OVF_I
                    & (state_q == ST_IDLE);
  assign edge_go = (start_mode == START_EDGE) & (state_q == ST_IDLE)
                   & (ctrl_q[C0_EDGE] ? pin_rise : pin_fall);
  assign now_go = wr_ctrl & (DAT_I[C0_START_HI:C0_START_LO] == START_NOW);
  assign start_go = running & (timer_go | edge_go | now_go);

  // Single step ends after each channel.
  assign step_end = (conv_mode == MODE_STEP) & CONV_DONE_I;

  // Intermediate interrupt after the fourth conversion of a set.
  assign four_hit = mode_b_q[MB_FOUR] & CONV_DONE_I & (conv_cnt_q == FOUR_CONV - 3'h1)
                    & ((conv_mode == MODE_CHAN)
                       | (((conv_mode == MODE_SCAN) | (conv_mode == MODE_SINGLE))
                          & (chan_count > MANY_CHANS)));

  assign done_set = (state_q == ST_BUSY) & (SET_DONE_I | step_end | four_hit);

  // Boundary criterion on each finished result of channel 0, or of every channel when MB_ALL is set.
  assign bound_set = CONV_DONE_I & (state_q == ST_BUSY)
                     & (mode_b_q[MB_INSIDE] ? RESULT_INSIDE_I : ~RESULT_INSIDE_I)
                     & (mode_b_q[MB_ALL] | (CONV_CHANNEL_I == 3'h0));

  // Bus handshake; ack rises one cycle after the request and falls next.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Read mux; reserved bits and unmapped addresses read zero.
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (ADR_I)
      CTRL0_ADR: rd_data = {24'h00_0000, ctrl_q};
      MODEA_ADR: rd_data = {24'h00_0000, mode_a_q};
      MODEB_ADR: rd_data = {24'h00_0000, mode_b_q};
      AINS_ADR: rd_data = {24'h00_0000, ains_q};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      dat_q <= 32'h0000_0000;
    end else if (req & ~WE_I) begin
      dat_q <= rd_data;
    end
  end

  // Control register zero; the complete flag set wins over a clear.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q <= REG_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= DAT_I[7:0];
        ctrl_q[C0_DONE] <= ctrl_q[C0_DONE] & DAT_I[C0_DONE];
      end
      if (done_set) begin
        ctrl_q[C0_DONE] <= 1'b1;
      end
    end
  end

  // Mode register A; boundary flag is cleared by writing zero.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_a_q <= REG_RESET;
    end else begin
      if (wr_mode_a) begin
        mode_a_q <= DAT_I[7:0] & MA_WMASK;
        mode_a_q[MA_BOUND] <= mode_a_q[MA_BOUND] & DAT_I[MA_BOUND];
      end
      if (bound_set) begin
        mode_a_q[MA_BOUND] <= 1'b1;
      end
    end
  end

  // Mode register B; reserved bits stay zero.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_b_q <= REG_RESET;
    end else if (wr_mode_b) begin
      mode_b_q <= DAT_I[7:0] & MB_WMASK;
    end
  end

  // Input-select register.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ains_q <= REG_RESET;
    end else if (wr_ains) begin
      ains_q <= DAT_I[7:0];
    end
  end

  // Three-stage pin synchroniser.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= EDGE_TRIGGER_PIN_I;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Filtered level; no edge counts before a first stable level is seen.
  // A pin that idles high still gives one rising edge after reset, as the zeroed stages count as a first stable low level.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      pin_lvl_q <= 1'b0;
      pin_seen_q <= 1'b0;
    end else if (pin_s2_q == pin_s3_q) begin
      pin_lvl_q <= pin_s3_q;
      pin_seen_q <= 1'b1;
    end
  end

  // Converter clock divider, one pulse every code plus one cycles.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      div_cnt_q <= 3'h0;
      clk_en_q <= 1'b0;
    end else if (!running) begin
      div_cnt_q <= 3'h0;
      clk_en_q <= 1'b0;
    end else if (div_cnt_q >= div_code) begin
      div_cnt_q <= 3'h0;
      clk_en_q <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1;
      clk_en_q <= 1'b0;
    end
  end

  // Conversion sequencing; Idle does not stop it, power-down does.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_go) begin
            state_q <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (!running || (wr_ctrl && DAT_I[C0_START_HI:C0_START_LO] == START_TIMER
                           && !DAT_I[C0_TIMER])) begin
            state_q <= ST_IDLE;
          end else if (SET_DONE_I || step_end) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Start pulse to the core, only from the idle state.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_go & (state_q == ST_IDLE);
    end
  end

  // Conversions counted within one set, for the intermediate interrupt.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      conv_cnt_q <= 3'h0;
    end else if (state_q == ST_IDLE) begin
      conv_cnt_q <= 3'h0;
    end else if (CONV_DONE_I && conv_cnt_q != FOUR_CONV) begin
      conv_cnt_q <= conv_cnt_q + 3'h1;
    end
  end

  // Converter power request.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      power_q <= 1'b0;
    end else begin
      power_q <= running;
    end
  end

  // Conversion mode towards the core.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_q <= MODE_STEP;
    end else begin
      mode_q <= conv_mode;
    end
  end

  // Per-input enables follow the select bits only while the converter runs.
  for (genvar g = 0; g < 8; g++) begin : g_ain
    always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
        ain_out_q[g] <= 1'b0;
      end else begin
        ain_out_q[g] <= ains_q[g] & running;
      end
    end
  end

  // Interrupt request from the complete and boundary flags.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= AD_IRQ_ENABLE_I & ((ctrl_q[C0_DONE] & ctrl_q[C0_DONE_IE])
                                  | (mode_a_q[MA_BOUND] & ctrl_q[C0_BOUND_IE]));
    end
  end

  // Wake request out of Idle on a completed conversion.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= IDLE_I & AD_IRQ_ENABLE_I & ctrl_q[C0_DONE] & ctrl_q[C0_DONE_IE];
    end
  end

  assign DAT_O = dat_q;
  assign ACK_O = ack_q;
  assign CONV_START_O = start_q;
  assign CONV_POWER_O = power_q;
  assign CONV_CLK_EN_O = clk_en_q;
  assign CONV_MODE_O = mode_q;
  assign INPUT_ENABLE_O = ain_out_q;
  assign IRQ_O = irq_q;
  assign WAKE_O = wake_q;
endmodule : acml_top
`default_nettype wire

// file: tb/acml_chk.sv
// Port checker for the converter control block.
// Assumes a bind to acml_top.
`timescale 1ns/1ns
`default_nettype none
module acml_chk (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O,
  input wire logic POWER_DOWN_I,
  input wire logic IDLE_I,
  input wire logic AD_IRQ_ENABLE_I,
  input wire logic CONV_START_O,
  input wire logic CONV_POWER_O,
  input wire logic [7:0] INPUT_ENABLE_O,
  input wire logic IRQ_O,
  input wire logic WAKE_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  sequence s_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_ack;
    ACK_O ##1 !ACK_O;
  endsequence
  AST_ACK: assert property (s_req |=> s_ack)
    else $error("ack missing or long");
  AST_NOACK: assert property (!CYC_I |=> !ACK_O)
    else $error("ack without request");
  AST_PDPWR: assert property (POWER_DOWN_I |=> !CONV_POWER_O)
    else $error("powered in power-down");
  AST_PDSTART: assert property (POWER_DOWN_I |=> !CONV_START_O)
    else $error("start in power-down");
  AST_BUSY: assert property (CONV_START_O |=> !CONV_START_O)
    else $error("start while busy");
  AST_IRQEN: assert property (IRQ_O |-> $past(AD_IRQ_ENABLE_I))
    else $error("irq while disabled");
  AST_WAKE: assert property (WAKE_O |-> IRQ_O && $past(IDLE_I))
    else $error("bad wake");
  AST_INSEL: assert property (POWER_DOWN_I |=> INPUT_ENABLE_O == 8'h00)
    else $error("inputs on in power-down");
endmodule : acml_chk
`default_nettype wire

// file: tb/acml_core_model.sv
// Analog core model: one conversion per start, then set done.
// Assumes the bench sets the latency.
`timescale 1ns/1ns
`default_nettype none
module acml_core_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [3:0] lat_i,
  output logic done_o,
  output logic set_o
);
  initial {done_o, set_o} = 2'h0;
  always @(posedge clk_i) begin
    if (start_i) begin
      repeat (lat_i) @(posedge clk_i);
      done_o <= 1'b1;
      @(posedge clk_i);
      done_o <= 1'b0;
      set_o <= 1'b1;
      @(posedge clk_i);
      set_o <= 1'b0;
    end
  end
endmodule : acml_core_model
`default_nettype wire

// file: tb/tb.sv
// Bench: bus tasks and one task per scenario.
// Assumes package, design, model and checker compile first.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import acml_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ovf = 1'b0;
  logic pin = 1'b1, idle = 1'b1, pd = 1'b0, irqen = 1'b1, ins = 1'b1;
  logic [11:0] adr = '0;
  logic [31:0] dat = '0, rdat, rword;
  logic [2:0] chan = 3'h0;
  logic [3:0] lat = 4'h1;
  logic ack, start, pwr, clken, irq, wake, done, setd;
  logic [2:0] mode;
  logic [7:0] inen;
  int num_errors = 0, comparisons = 0, starts = 0;
  always #10 clk = ~clk;
  always @(posedge clk) if (start === 1'b1) starts++;
  acml_top DUT (.MCLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(4'hF), .DAT_I(dat), .DAT_O(rdat), .ACK_O(ack), .TIMER0_OVF_I(ovf),
    .EDGE_TRIGGER_PIN_I(pin), .IDLE_I(idle), .POWER_DOWN_I(pd), .AD_IRQ_ENABLE_I(irqen),
    .CONV_DONE_I(done), .SET_DONE_I(setd), .CONV_CHANNEL_I(chan), .RESULT_INSIDE_I(ins),
    .CONV_START_O(start), .CONV_POWER_O(pwr), .CONV_CLK_EN_O(clken), .CONV_MODE_O(mode),
    .INPUT_ENABLE_O(inen), .IRQ_O(irq), .WAKE_O(wake));
  acml_core_model core (.clk_i(clk), .start_i(start), .lat_i(lat), .done_o(done), .set_o(setd));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rword = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rd(input string n, input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(n, {24'h0, e}, rword);
  endtask : rd
  task automatic t_regs();
    rd("ctrl0", CTRL0_ADR, REG_RESET);
    bus(1'b1, MODEA_ADR, 8'hFF);
    rd("modea", MODEA_ADR, 8'h70);
    bus(1'b1, MODEB_ADR, 8'hFF);
    rd("modeb", MODEB_ADR, 8'hF3);
    bus(1'b1, 12'h004, 8'hFF);
    rd("unmapped", 12'h004, 8'h00);
  endtask : t_regs
  task automatic t_div();
    int n;
    bus(1'b1, CTRL0_ADR, 8'h04);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, MODEB_ADR, {c[2:0], 5'h00});
      n = 0;
      do @(posedge clk); while (clken !== 1'b1 && ++n < 40);
      n = 0;
      do @(posedge clk); while (++n < 40 && clken !== 1'b1);
      chk("divider", 32'(c + 1), 32'(n));
    end
  endtask : t_div
  task automatic t_imm();
    int s = starts;
    bus(1'b1, MODEA_ADR, 8'h00);
    bus(1'b1, CTRL0_ADR, 8'h44);
    bus(1'b1, CTRL0_ADR, 8'h45);
    repeat (10) @(posedge clk);
    chk("starts", 32'(s + 1), 32'(starts));
    chk("step mode", 32'h0, 32'(mode));
    rd("ctrl0", CTRL0_ADR, 8'h4D);
    chk("irq", 32'h1, 32'(irq));
    chk("wake", 32'h1, 32'(wake));
    bus(1'b1, CTRL0_ADR, 8'h44);
    chk("irq clr", 32'h0, 32'(irq));
  endtask : t_imm
  task automatic t_timer();
    int s = starts;
    lat <= 4'h8;
    bus(1'b1, CTRL0_ADR, 8'h24);
    for (int k = 0; k < 5; k++) begin
      ovf <= (k != 4);
      @(posedge clk);
      ovf <= 1'b0;
      repeat (k[0] ? 30 : 3) @(posedge clk);
      if (k == 3) bus(1'b1, CTRL0_ADR, 8'h04);
    end
    chk("timer starts", 32'(s + 2), 32'(starts));
    lat <= 4'h1;
  endtask : t_timer
  task automatic t_edge();
    int s;
    for (int e = 0; e < 2; e++) begin
      pin <= ~e[0];
      bus(1'b1, CTRL0_ADR, {3'h0, e[0], 4'h6});
      repeat (6) @(posedge clk);
      s = starts;
      pin <= e[0];
      repeat (12) @(posedge clk);
      pin <= ~e[0];
      repeat (12) @(posedge clk);
      chk("edge starts", 32'(s + 1), 32'(starts));
    end
  endtask : t_edge
  task automatic t_bound();
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, MODEA_ADR, 8'h10 << m);
      chk("mode", 32'h1 << m, 32'(mode));
    end
    bus(1'b1, MODEA_ADR, 8'h10);
    bus(1'b1, MODEB_ADR, 8'hF2);
    bus(1'b1, CTRL0_ADR, 8'h85);
    repeat (10) @(posedge clk);
    rd("bound inside", MODEA_ADR, 8'h90);
    chk("bound irq", 32'h1, 32'(irq));
    bus(1'b1, MODEA_ADR, 8'h10);
    chk("bound clr", 32'h0, 32'(irq));
    chan <= 3'h3;
    bus(1'b1, MODEB_ADR, 8'hF0);
    bus(1'b1, CTRL0_ADR, 8'h85);
    repeat (10) @(posedge clk);
    rd("bound ch0 only", MODEA_ADR, 8'h10);
    bus(1'b1, MODEB_ADR, 8'hE2);
    bus(1'b1, CTRL0_ADR, 8'h85);
    repeat (10) @(posedge clk);
    rd("bound outside", MODEA_ADR, 8'h10);
    chan <= 3'h0;
  endtask : t_bound
  task automatic t_pd();
    int s = starts;
    bus(1'b1, CTRL0_ADR, 8'h04);
    bus(1'b1, AINS_ADR, 8'hA5);
    chk("inputs", 32'h0A5, 32'(inen));
    pd <= 1'b1;
    bus(1'b1, CTRL0_ADR, 8'h05);
    repeat (8) @(posedge clk);
    chk("pd starts", 32'(s), 32'(starts));
    chk("pd power", 32'h0, 32'(pwr));
    pd <= 1'b0;
  endtask : t_pd
  task automatic final_report();
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_div();
    t_imm();
    t_timer();
    t_edge();
    t_bound();
    t_pd();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule : tb
bind acml_top acml_chk u_chk (.MCLK_I(MCLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I),
  .ACK_O(ACK_O), .POWER_DOWN_I(POWER_DOWN_I), .IDLE_I(IDLE_I), .AD_IRQ_ENABLE_I(AD_IRQ_ENABLE_I),
  .CONV_START_O(CONV_START_O), .CONV_POWER_O(CONV_POWER_O), .INPUT_ENABLE_O(INPUT_ENABLE_O),
  .IRQ_O(IRQ_O), .WAKE_O(WAKE_O));
`default_nettype wire
